// ==== hw/oppe_pkg.sv ====
// ****************************************************************
// operand and system bus event counter constants
// ****************************************************************
package oppe_pkg;

   // counter geometry
   localparam int unsigned OPPE_CNT_W    = 32;
   localparam int unsigned OPPE_NUM_CH   = 4;
   localparam int unsigned OPPE_SEL_W    = 4;
   localparam int unsigned OPPE_NUM_EV   = 15;
   localparam int unsigned OPPE_ADDR_W   = 12;

   // channel indices of counter_channel_three and counter_channel_four
   localparam int unsigned OPPE_CH_THREE = 2;
   localparam int unsigned OPPE_CH_FOUR  = 3;

   // register byte offsets
   localparam logic [11:0] OPPE_CTRL_OFF     = 12'h000;
   localparam logic [11:0] OPPE_STATUS_OFF   = 12'h004;
   localparam logic [11:0] OPPE_SEL_BASE     = 12'h010;
   localparam logic [11:0] OPPE_CNT_BASE     = 12'h020;

   // control fields
   localparam int unsigned OPPE_CTRL_EN_LSB  = 0;
   localparam int unsigned OPPE_CTRL_CHAIN_A = 4;
   localparam int unsigned OPPE_CTRL_CHAIN_B = 5;
   localparam int unsigned OPPE_CTRL_CLEAR   = 8;

   // reset values
   localparam logic [3:0]  OPPE_EN_RST       = 4'h0;
   localparam logic [1:0]  OPPE_CHAIN_RST    = 2'h0;
   localparam logic [3:0]  OPPE_OVF_RST      = 4'h0;

   // selectable event codes, in software encoding order
   typedef enum logic [3:0] {
      OPPE_EV_NONE,
      OPPE_EV_XY_WR,
      OPPE_EV_UR_RD,
      OPPE_EV_UR_WR,
      OPPE_EV_CM_RD,
      OPPE_EV_CM_WR,
      OPPE_EV_UB_MISS,
      OPPE_EV_WAIT_RD,
      OPPE_EV_WAIT_WR,
      OPPE_EV_WAIT_CM_RD,
      OPPE_EV_WAIT_CM_WR,
      OPPE_EV_SB_REQ,
      OPPE_EV_SB_RSP,
      OPPE_EV_SB_REQ_WAIT,
      OPPE_EV_SB_RSP_WAIT
   } oppe_event_e;

endpackage

// ==== hw/oppe_counter.sv ====
`timescale 1ns/10ps
// ****************************************************************
// one result counter channel
// ****************************************************************
module oppe_counter #(
   parameter int unsigned W = 32
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         clr,
   input  wire logic         inc,
   output logic [W-1:0]      count_q,
   output logic              wrap
);

   // carry out towards a chained upper half
   assign wrap = inc & (&count_q) & ~clr;

   // clear beats increment so a restart never shows a stale step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_q <= '0;
      end else if (ce) begin
         if (clr) begin
            count_q <= '0;
         end else if (inc) begin
            count_q <= count_q + 1'b1; // R17
         end
      end
   end

   property p_cnt_step;
      @(posedge clk) disable iff (!resetn)
      (ce && inc && !clr) |=> (count_q == W'($past(count_q) + 1'b1));
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter did not step by one"); // R17

endmodule // oppe_counter

// ==== hw/oppe_top.sv ====
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// R1: xy write event counts operand writes via xy bus and operand bus.
// R2: simultaneous x and y data moves add exactly one xy count.
// R3: unified ram read and write counted apart, cache-routed accesses excluded.
// R4: operand cache read miss event counts every read miss leaving the core.
// R5: prefetch instruction misses never count as read or write misses.
// R6: operand cache write misses counted, write-through accesses excluded.
// R7: unified ram read buffer misses form a selectable event.
// R8: operand read wait and write wait cycles are separate events.
// R9: read miss wait includes cache fill waits from contention.
// R10: write miss wait counts cycles caused by operand cache write misses.
// R11: system bus cells counted per bus clock, only on channels three, four.
// R12: request wait counts bus clocks with a request lacking its grant.
// R13: response wait counts bus clocks with a response lacking its grant.
// R14: many waiting requests in one cycle add a single count.
// R15: counters run on the cpu clock and freeze while it is halted.
// R16: counters are 32 bits, pairs chain into one 64-bit counter.
// R17: software picks one event per channel; each qualifying cycle adds one.
module oppe_top
   import oppe_pkg::*;
#(
   parameter int unsigned NUM_REQ = 2,
   parameter int unsigned CNT_W   = oppe_pkg::OPPE_CNT_W
) (
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         ce,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [oppe_pkg::OPPE_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // operand bus qualifiers
   input  wire logic                         xy_wr_xybus,
   input  wire logic                         xy_wr_opbus,
   input  wire logic                         x_data_move,
   input  wire logic                         y_data_move,
   input  wire logic                         uram_rd,
   input  wire logic                         uram_wr,
   input  wire logic                         uram_via_cache,
   input  wire logic                         opc_rd_miss,
   input  wire logic                         opc_wr_miss,
   input  wire logic                         prefetch_instruction,
   input  wire logic                         opc_write_through,
   input  wire logic                         uram_readbuf_miss,
   input  wire logic                         op_rd_wait,
   input  wire logic                         op_wr_wait,
   input  wire logic                         rd_miss_wait,
   input  wire logic                         fill_contention_wait,
   input  wire logic                         wr_miss_wait,
   // system bus qualifiers
   input  wire logic                         sb_clk_tick,
   input  wire logic                         sb_req_cell,
   input  wire logic                         sb_rsp_cell,
   input  wire logic [NUM_REQ-1:0]           sb_req_pend,
   input  wire logic [NUM_REQ-1:0]           sb_req_gnt,
   input  wire logic [NUM_REQ-1:0]           sb_rsp_pend,
   input  wire logic [NUM_REQ-1:0]           sb_rsp_gnt
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
      $error("counter width must lie in 1..32");
   end
   if (NUM_REQ < 1) begin : g_bad_req
      $error("at least one system bus requester is needed");
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // system bus items exist only on the upper two channels
   function automatic logic is_sys(input logic [OPPE_SEL_W-1:0] code);
      return (code >= OPPE_SEL_W'(OPPE_EV_SB_REQ)) && (code <= OPPE_SEL_W'(OPPE_EV_SB_RSP_WAIT));
   endfunction

   // picks the selected event; unknown codes and misplaced bus items count nothing
   function automatic logic ev_pick(input logic [OPPE_SEL_W-1:0]  code,
                                    input logic [OPPE_NUM_EV-1:0] ev,
                                    input logic                   sys_ok);
      logic hit;
      hit = 1'b0;
      if (code < OPPE_SEL_W'(OPPE_NUM_EV)) begin
         hit = ev[code];
      end
      if (is_sys(code) && !sys_ok) begin
         hit = 1'b0;
      end
      return hit;
   endfunction

   // ****************************************************************
   // event qualification
   // ****************************************************************
   logic [OPPE_NUM_EV-1:0] ev;
   logic                   req_waiting;
   logic                   rsp_waiting;

   // or-reduction keeps several waiting requesters to one count per cycle
   assign req_waiting = |(sb_req_pend & ~sb_req_gnt); // R12 R14
   assign rsp_waiting = |(sb_rsp_pend & ~sb_rsp_gnt); // R13 R14

   // one bit per event code, each at most one per cycle
   always_comb begin
      ev                          = '0;
      ev[OPPE_EV_XY_WR]           = xy_wr_xybus | xy_wr_opbus | (x_data_move & y_data_move); // R1 R2
      ev[OPPE_EV_UR_RD]           = uram_rd & ~uram_via_cache; // R3
      ev[OPPE_EV_UR_WR]           = uram_wr & ~uram_via_cache; // R3
      ev[OPPE_EV_CM_RD]           = opc_rd_miss & ~prefetch_instruction; // R4 R5
      ev[OPPE_EV_CM_WR]           = opc_wr_miss & ~opc_write_through & ~prefetch_instruction; // R5 R6
      ev[OPPE_EV_UB_MISS]         = uram_readbuf_miss; // R7
      ev[OPPE_EV_WAIT_RD]         = op_rd_wait; // R8
      ev[OPPE_EV_WAIT_WR]         = op_wr_wait; // R8
      ev[OPPE_EV_WAIT_CM_RD]      = rd_miss_wait | fill_contention_wait; // R9
      ev[OPPE_EV_WAIT_CM_WR]      = wr_miss_wait; // R10
      // bus items sample once per system bus clock, marked by the tick
      ev[OPPE_EV_SB_REQ]          = sb_clk_tick & sb_req_cell; // R11
      ev[OPPE_EV_SB_RSP]          = sb_clk_tick & sb_rsp_cell; // R11
      ev[OPPE_EV_SB_REQ_WAIT]     = sb_clk_tick & req_waiting; // R12
      ev[OPPE_EV_SB_RSP_WAIT]     = sb_clk_tick & rsp_waiting; // R13
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [OPPE_NUM_CH-1:0] en_q;
   logic [1:0]             chain_q;
   logic [OPPE_NUM_CH-1:0] ovf_q;
   logic [OPPE_SEL_W-1:0]  sel_q [OPPE_NUM_CH];
   logic [CNT_W-1:0]       cnt   [OPPE_NUM_CH];
   logic [OPPE_NUM_CH-1:0] wrap;
   logic [OPPE_NUM_CH-1:0] inc;
   logic [OPPE_NUM_CH-1:0] ovf_set;
   logic                   wr_acc;
   logic                   setup;
   logic                   clr;
   logic [31:0]            rd_d;
   logic                   err_d;

   // a frozen clock stalls the bus as well, so no write can slip past
   assign pready = ce;
   assign wr_acc = psel & penable & pwrite & ce;
   assign setup  = psel & ~penable & ce;
   assign clr    = wr_acc && (paddr == OPPE_CTRL_OFF) && pwdata[OPPE_CTRL_CLEAR];

   // address decode for reads and for the error answer
   always_comb begin
      rd_d  = 32'h0;
      err_d = 1'b0;
      if (paddr == OPPE_CTRL_OFF) begin
         rd_d[OPPE_CTRL_EN_LSB +: OPPE_NUM_CH] = en_q;
         rd_d[OPPE_CTRL_CHAIN_A]               = chain_q[0];
         rd_d[OPPE_CTRL_CHAIN_B]               = chain_q[1];
      end else if (paddr == OPPE_STATUS_OFF) begin
         rd_d[OPPE_NUM_CH-1:0] = ovf_q;
      end else if ((paddr[11:4] == OPPE_SEL_BASE[11:4]) && (paddr[1:0] == 2'h0)) begin
         rd_d[OPPE_SEL_W-1:0] = sel_q[paddr[3:2]];
      end else if ((paddr[11:4] == OPPE_CNT_BASE[11:4]) && (paddr[1:0] == 2'h0)) begin
         rd_d[CNT_W-1:0] = cnt[paddr[3:2]];
      end else begin
         err_d = 1'b1;
      end
   end

   // read data is captured in the setup phase and shown in the access phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0 : rd_d;
         pslverr <= err_d;
      end
   end

   // control word: channel enables and the two chain bits
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_q    <= OPPE_EN_RST;
         chain_q <= OPPE_CHAIN_RST;
      end else if (wr_acc && (paddr == OPPE_CTRL_OFF)) begin
         en_q       <= pwdata[OPPE_CTRL_EN_LSB +: OPPE_NUM_CH];
         chain_q[0] <= pwdata[OPPE_CTRL_CHAIN_A];
         chain_q[1] <= pwdata[OPPE_CTRL_CHAIN_B];
      end
   end

   // event selects, one per channel
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < OPPE_NUM_CH; i++) begin
            sel_q[i] <= OPPE_SEL_W'(OPPE_EV_NONE);
         end
      end else if (wr_acc && (paddr[11:4] == OPPE_SEL_BASE[11:4]) && (paddr[1:0] == 2'h0)) begin
         sel_q[paddr[3:2]] <= pwdata[OPPE_SEL_W-1:0]; // R17
      end
   end

   // sticky overflow, write one to clear; a new overflow wins over the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ovf_q <= OPPE_OVF_RST;
      end else if (ce) begin
         if (wr_acc && (paddr == OPPE_STATUS_OFF)) begin
            ovf_q <= (ovf_q & ~pwdata[OPPE_NUM_CH-1:0]) | ovf_set;
         end else if (clr) begin
            ovf_q <= OPPE_OVF_RST;
         end else begin
            ovf_q <= ovf_q | ovf_set;
         end
      end
   end

   // ****************************************************************
   // counter channels
   // ****************************************************************

   // an upper half in a chain follows the lower carry instead of its own event
   always_comb begin
      for (int i = 0; i < OPPE_NUM_CH; i++) begin
         inc[i] = en_q[i] & ev_pick(sel_q[i], ev, (i == OPPE_CH_THREE) || (i == OPPE_CH_FOUR)); // R11 R17
      end
      if (chain_q[0]) begin
         inc[1] = wrap[0]; // R16
      end
      if (chain_q[1]) begin
         inc[OPPE_CH_FOUR] = wrap[OPPE_CH_THREE]; // R16
      end
      ovf_set    = wrap;
      ovf_set[0] = wrap[0] & ~chain_q[0];
      ovf_set[OPPE_CH_THREE] = wrap[OPPE_CH_THREE] & ~chain_q[1];
   end

   // ce is the cpu clock gate: sleep stops every channel
   for (genvar g = 0; g < OPPE_NUM_CH; g++) begin : g_ch
      oppe_counter #(
         .W       (CNT_W)
      ) u_cnt (
         .clk     (clk),
         .resetn  (resetn),
         .ce      (ce), // R15
         .clr     (clr),
         .inc     (inc[g]),
         .count_q (cnt[g]),
         .wrap    (wrap[g])
      );
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic quiet0;
   assign quiet0 = ce && !clr && en_q[0];

   property p_xy_opbus;
      quiet0 && (sel_q[0] == OPPE_SEL_W'(OPPE_EV_XY_WR)) && xy_wr_opbus
      |=> (cnt[0] == CNT_W'($past(cnt[0]) + 1'b1));
   endproperty
   a_xy_opbus: assert property (p_xy_opbus) else $error("xy write via operand bus not counted"); // R1

   property p_dual_move;
      quiet0 && (sel_q[0] == OPPE_SEL_W'(OPPE_EV_XY_WR)) && x_data_move && y_data_move
      |=> (cnt[0] == CNT_W'($past(cnt[0]) + 1'b1));
   endproperty
   a_dual_move: assert property (p_dual_move) else $error("dual move did not add exactly one"); // R2

   property p_uram_cache;
      quiet0 && (sel_q[0] == OPPE_SEL_W'(OPPE_EV_UR_RD)) && uram_via_cache
      |=> (cnt[0] == $past(cnt[0]));
   endproperty
   a_uram_cache: assert property (p_uram_cache) else $error("cached unified ram read was counted"); // R3

   property p_prefetch;
      quiet0 && ((sel_q[0] == OPPE_SEL_W'(OPPE_EV_CM_RD)) || (sel_q[0] == OPPE_SEL_W'(OPPE_EV_CM_WR)))
      && prefetch_instruction |=> $stable(cnt[0]);
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("prefetch miss was counted"); // R5

   property p_wthru;
      quiet0 && (sel_q[0] == OPPE_SEL_W'(OPPE_EV_CM_WR)) && opc_write_through |=> $stable(cnt[0]);
   endproperty
   a_wthru: assert property (p_wthru) else $error("write-through miss was counted"); // R6

   property p_sys_low_ch;
      ce && !clr && !chain_q[0] && is_sys(sel_q[1]) |=> $stable(cnt[1]);
   endproperty
   a_sys_low_ch: assert property (p_sys_low_ch) else $error("bus item counted on a lower channel"); // R11

   property p_req_wait_once;
      ce && !clr && en_q[OPPE_CH_THREE] && (sel_q[OPPE_CH_THREE] == OPPE_SEL_W'(OPPE_EV_SB_REQ_WAIT))
      && sb_clk_tick && req_waiting
      |=> (cnt[OPPE_CH_THREE] == CNT_W'($past(cnt[OPPE_CH_THREE]) + 1'b1));
   endproperty
   a_req_wait_once: assert property (p_req_wait_once) else $error("request wait not counted once"); // R12 R14

   property p_rsp_wait_tick;
      ce && !clr && (sel_q[OPPE_CH_FOUR] == OPPE_SEL_W'(OPPE_EV_SB_RSP_WAIT)) && !chain_q[1] && !sb_clk_tick
      |=> $stable(cnt[OPPE_CH_FOUR]);
   endproperty
   a_rsp_wait_tick: assert property (p_rsp_wait_tick) else $error("response wait counted off the bus clock"); // R13

   property p_sleep;
      !ce |=> ($stable(cnt[0]) && $stable(cnt[1]) && $stable(cnt[2]) && $stable(cnt[3]) && $stable(ovf_q));
   endproperty
   a_sleep: assert property (p_sleep) else $error("state moved while the clock was halted"); // R15

   property p_chain;
      ce && chain_q[0] && wrap[0] |=> (cnt[0] == '0) && (cnt[1] == CNT_W'($past(cnt[1]) + 1'b1)) && !ovf_q[0];
   endproperty
   a_chain: assert property (p_chain) else $error("chained upper half missed the carry"); // R16

   property p_ovf_set_wins;
      ce && ovf_set[OPPE_CH_THREE] |=> ovf_q[OPPE_CH_THREE];
   endproperty
   a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("overflow lost against a clear");

   property p_rd_miss;
      ce && !clr && en_q[1] && !chain_q[0] && (sel_q[1] == OPPE_SEL_W'(OPPE_EV_CM_RD)) && opc_rd_miss
      && !prefetch_instruction |=> (cnt[1] == CNT_W'($past(cnt[1]) + 1'b1));
   endproperty
   a_rd_miss: assert property (p_rd_miss) else $error("operand cache read miss not counted"); // R4

   property p_fill_wait;
      ce && !clr && en_q[OPPE_CH_FOUR] && !chain_q[1] && (sel_q[OPPE_CH_FOUR] == OPPE_SEL_W'(OPPE_EV_WAIT_CM_RD))
      && fill_contention_wait |=> (cnt[OPPE_CH_FOUR] == CNT_W'($past(cnt[OPPE_CH_FOUR]) + 1'b1));
   endproperty
   a_fill_wait: assert property (p_fill_wait) else $error("cache fill contention wait not counted"); // R9

   property p_req_cell;
      ce && !clr && en_q[OPPE_CH_THREE] && (sel_q[OPPE_CH_THREE] == OPPE_SEL_W'(OPPE_EV_SB_REQ))
      && sb_clk_tick && sb_req_cell |=> (cnt[OPPE_CH_THREE] == CNT_W'($past(cnt[OPPE_CH_THREE]) + 1'b1));
   endproperty
   a_req_cell: assert property (p_req_cell) else $error("bus request cell not counted"); // R11

   // clear must leave every channel and every overflow bit at rest
   property p_clear_all;
      ce && clr |=> (cnt[0] == '0) && (cnt[1] == '0) && (cnt[2] == '0) && (cnt[3] == '0) && (ovf_q == OPPE_OVF_RST);
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear left a counter or overflow bit set");

endmodule // oppe_top

// ==== bench/oppe_evsrc.sv ====
`timescale 1ns/10ps
// ****************************************************************
// core-side event source: drives the qualifier lines into the counters
// ****************************************************************
module oppe_evsrc (
   input  wire logic        clk,
   output logic [27:0]      ev
);
   // idle is all-zero: the qualifiers are single-cycle levels, not a bus
   initial ev = 28'h0;

   // hold one qualifier pattern for n cycles, then drop it
   task automatic drive(input logic [27:0] p, input int n);
      repeat (n) begin
         @(posedge clk);
         ev <= p;
      end
      @(posedge clk);
      ev <= 28'h0;
   endtask
endmodule // oppe_evsrc

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
// ****************************************************************
// self-checking bench for the event counters
// ****************************************************************
module testbench;
   import oppe_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e;
   logic [27:0] ev;
   int fail_count = 0, n_tests = 0;
   logic [3:0] code;
   logic [1:0] ch;
   logic x;
   logic [27:0] pat;
   // code, channel index, counts-per-cycle, qualifier pattern
   logic [34:0] tbl [$] = '{
      {4'h1, 2'h0, 1'b1, 28'h0000001},
      {4'h1, 2'h0, 1'b1, 28'h0000002},
      {4'h1, 2'h0, 1'b1, 28'h000000c},
      {4'h2, 2'h2, 1'b1, 28'h0000010},
      {4'h2, 2'h0, 1'b0, 28'h0000050},
      {4'h2, 2'h1, 1'b0, 28'h0000020},
      {4'h3, 2'h3, 1'b1, 28'h0000020},
      {4'h3, 2'h0, 1'b0, 28'h0000060},
      {4'h4, 2'h1, 1'b1, 28'h0000080},
      {4'h4, 2'h2, 1'b0, 28'h0000280},
      {4'h5, 2'h3, 1'b1, 28'h0000100},
      {4'h5, 2'h0, 1'b0, 28'h0000500},
      {4'h5, 2'h0, 1'b0, 28'h0000300},
      {4'h6, 2'h2, 1'b1, 28'h0000800},
      {4'h7, 2'h3, 1'b1, 28'h0001000},
      {4'h7, 2'h0, 1'b0, 28'h0002000},
      {4'h8, 2'h1, 1'b1, 28'h0002000},
      {4'h9, 2'h2, 1'b1, 28'h0004000},
      {4'h9, 2'h3, 1'b1, 28'h0008000},
      {4'ha, 2'h0, 1'b1, 28'h0010000},
      {4'hb, 2'h2, 1'b1, 28'h0060000},
      {4'hb, 2'h3, 1'b0, 28'h0040000},
      {4'hb, 2'h0, 1'b0, 28'h0060000},
      {4'hc, 2'h3, 1'b1, 28'h00a0000},
      {4'hc, 2'h1, 1'b0, 28'h00a0000},
      {4'hd, 2'h2, 1'b1, 28'h0320000},
      {4'hd, 2'h3, 1'b0, 28'h0f20000},
      {4'hd, 2'h2, 1'b0, 28'h0300000},
      {4'he, 2'h3, 1'b1, 28'h3020000},
      {4'he, 2'h2, 1'b0, 28'hf020000},
      {4'h0, 2'h0, 1'b0, 28'h0000001}
   };

   initial begin
      forever #2.5 clk = ~clk;
   end

   oppe_evsrc EV (.clk(clk), .ev(ev));

   // small counter width so that wrap and chaining stay short
   oppe_top #(.NUM_REQ(2), .CNT_W(4)) DUT (
      .clk(clk), .resetn(resetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xy_wr_xybus(ev[0]), .xy_wr_opbus(ev[1]), .x_data_move(ev[2]), .y_data_move(ev[3]),
      .uram_rd(ev[4]), .uram_wr(ev[5]), .uram_via_cache(ev[6]), .opc_rd_miss(ev[7]),
      .opc_wr_miss(ev[8]), .prefetch_instruction(ev[9]), .opc_write_through(ev[10]),
      .uram_readbuf_miss(ev[11]), .op_rd_wait(ev[12]), .op_wr_wait(ev[13]),
      .rd_miss_wait(ev[14]), .fill_contention_wait(ev[15]), .wr_miss_wait(ev[16]),
      .sb_clk_tick(ev[17]), .sb_req_cell(ev[18]), .sb_rsp_cell(ev[19]),
      .sb_req_pend(ev[21:20]), .sb_req_gnt(ev[23:22]),
      .sb_rsp_pend(ev[25:24]), .sb_rsp_gnt(ev[27:26])
   );

   // one apb transfer; a stuck pready is left to the watchdog, never cut short here
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, OPPE_CTRL_OFF, 32'h0);   chk(r, 32'h0);
      apb(1'b0, OPPE_STATUS_OFF, 32'h0); chk(r, 32'h0);
      apb(1'b0, OPPE_CNT_BASE, 32'h0);   chk(r, 32'h0);
      apb(1'b0, 12'h100, 32'h0);         chk({r[30:0], e}, 32'h1);
      // every code on a mix of channels, each pattern driven for three cycles, qualifying or not
      foreach (tbl[i]) begin
         {code, ch, x, pat} = tbl[i];
         apb(1'b1, OPPE_SEL_BASE + 12'({ch, 2'b00}), {28'h0, code});
         apb(1'b1, OPPE_CTRL_OFF, 32'h100 | (32'h1 << ch));
         EV.drive(pat, 3);
         apb(1'b0, OPPE_CNT_BASE + 12'({ch, 2'b00}), 32'h0);
         chk(r, x ? 32'h3 : 32'h0);
      end
      // gated cpu clock: qualifiers while ce is low must not count
      apb(1'b1, OPPE_SEL_BASE, 32'h7);
      apb(1'b1, OPPE_CTRL_OFF, 32'h101);
      ce <= 1'b0;
      EV.drive(28'h0001000, 3);
      ce <= 1'b1;
      apb(1'b0, OPPE_CNT_BASE, 32'h0);   chk(r, 32'h0);
      // ch1+ch2 chained, ch3 free: 17 events wrap ch1 and ch3 once, ch2 takes the one carry
      apb(1'b1, OPPE_SEL_BASE + 12'h8, 32'h7);
      apb(1'b1, OPPE_CTRL_OFF, 32'h115);
      EV.drive(28'h0001000, 17);
      apb(1'b0, OPPE_CNT_BASE, 32'h0);         chk(r, 32'h1);
      apb(1'b0, OPPE_CNT_BASE + 12'h4, 32'h0); chk(r, 32'h1);
      apb(1'b0, OPPE_CNT_BASE + 12'h8, 32'h0); chk(r, 32'h1);
      apb(1'b0, OPPE_STATUS_OFF, 32'h0);       chk(r, 32'h4);
      apb(1'b1, OPPE_STATUS_OFF, 32'h4);
      apb(1'b0, OPPE_STATUS_OFF, 32'h0);       chk(r, 32'h0);
      // counters are read-only from the bus
      apb(1'b1, OPPE_CNT_BASE + 12'h8, 32'hff);
      apb(1'b0, OPPE_CNT_BASE + 12'h8, 32'h0); chk({r[30:0], e}, 32'h2);
      stop_test();
   end

   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      #100us;
      fail_count++;
      stop_test();
   end
endmodule // testbench
